// [hdl/iesb_status_bank.sv]
// Purpose: standard event and activity status bank
// Assumes: commands decoded upstream, inputs synchronous
// Notes: answers wait in one buffer until the controller reads or sends another command
`timescale 1ns/1ps
`default_nettype none

module iesb_status_bank #(
    parameter int DATA_W = 16,
    parameter bit SYNC_AVAIL_EN = 1'b1
) (
    // Clock, reset and freeze
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Decoded controller commands
    input wire logic cmd_valid,
    input wire iesb_pkg::iesb_cmd_type cmd_code,
    input wire logic [DATA_W-1:0] cmd_data,
    input wire logic talk_req,
    // Answer toward the controller
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    // Protocol and instrument events
    input wire logic exec_idle,
    input wire logic cmd_error,
    input wire logic exec_error,
    input wire logic dev_error,
    input wire logic local_to_manual,
    // Error queue entries
    output logic err_push,
    output logic [15:0] err_code,
    // Activity conditions
    input wire logic autorange_switching,
    input wire logic memory_recording_active,
    input wire logic pretrigger_fill,
    input wire logic trig_wait,
    input wire logic recording_armed,
    input wire logic sync_locked,
    input wire logic sync_enabled,
    input wire logic sync_available,
    input wire logic averaging_active,
    input wire logic calc_running,
    // Summary flags
    output logic event_summary_flag,
    output logic activity_summary_flag,
    output logic opc_pending
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (DATA_W < iesb_pkg::OPR_W) begin : g_chk
        $error("DATA_W must hold the activity register");
    end

    // ****************************************
    // Declarations
    // ****************************************
    iesb_latch_if #(.W(iesb_pkg::EVL_W)) evl_if (); // Event latch
    iesb_latch_if #(.W(iesb_pkg::OPR_W)) oev_if (); // Activity latch

    logic [7:0] evm_ff; // Event mask
    logic [15:0] oen_ff; // Activity event mask
    logic [15:0] cond_ff; // Activity condition
    logic [15:0] nxt_cond; // Next activity condition
    logic opc_wait_ff; // Waiting for command completion
    logic rsp_valid_ff; // Answer strobe
    logic [DATA_W-1:0] rsp_data_ff; // Buffered answer
    logic err_push_ff; // Error entry strobe
    logic [15:0] err_code_ff; // Error entry code
    logic evsum_ff; // Event summary
    logic asum_ff; // Activity summary
    logic is_query; // Command produces an answer
    logic other_cmd; // Command without answer
    logic is_cls; // Clear-status command
    logic query_err; // Query protocol error
    logic talk_ok; // Buffered answer read
    logic answer_held; // Answer waiting
    logic opc_done; // Completion event

    // ****************************************
    // Command decode
    // ****************************************

    // Commands that load the answer buffer
    always_comb begin
        is_query = 1'b0;
        if (cmd_valid) begin
            unique case (cmd_code)
                iesb_pkg::CMD_RD_EVL,
                iesb_pkg::CMD_RD_EVM,
                iesb_pkg::CMD_RD_OCON,
                iesb_pkg::CMD_RD_OEVT,
                iesb_pkg::CMD_RD_OENA: begin
                    is_query = 1'b1;
                end
                default: begin
                    is_query = 1'b0;
                end
            endcase
        end
    end

    assign other_cmd = cmd_valid & ~is_query;
    assign is_cls = cmd_valid & (cmd_code == iesb_pkg::CMD_CLS);

    // Answer tracking and query error detection
    iesb_query_guard u_guard (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .query_cmd(is_query),
        .other_cmd(other_cmd),
        .talk_req(talk_req),
        .query_err(query_err),
        .talk_ok(talk_ok),
        .answer_held(answer_held)
    );

    // ****************************************
    // Operation complete
    // ****************************************

    // Completion seen while an OPC waits
    assign opc_done = opc_wait_ff & exec_idle;

    // Arm on OPC, disarm on completion or clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            opc_wait_ff <= 1'b0;
        end else if (ce) begin
            if (cmd_valid && cmd_code == iesb_pkg::CMD_OPC) begin
                opc_wait_ff <= 1'b1;
            end else if (opc_done || is_cls) begin
                opc_wait_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Standard event latch
    // ****************************************

    // Event sources into the latch
    always_comb begin
        evl_if.set_bits = '0;
        evl_if.set_bits[iesb_pkg::EVL_OPC] = opc_done;
        evl_if.set_bits[iesb_pkg::EVL_QRY] = query_err;
        evl_if.set_bits[iesb_pkg::EVL_DEV] = dev_error;
        evl_if.set_bits[iesb_pkg::EVL_EXE] = exec_error;
        evl_if.set_bits[iesb_pkg::EVL_CMD] = cmd_error;
        evl_if.set_bits[iesb_pkg::EVL_URQ] = local_to_manual;
    end

    // Reading the latch or clearing status empties it
    assign evl_if.clr_bits = {iesb_pkg::EVL_W{(cmd_valid &&
        cmd_code == iesb_pkg::CMD_RD_EVL) || is_cls}};

    // Power-on value sets bit 7 at every switch-on
    iesb_event_latch #(
        .W(iesb_pkg::EVL_W),
        .USED(iesb_pkg::EVL_USED),
        .RST(iesb_pkg::EVL_RST)
    ) u_evl (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .lif(evl_if.lat)
    );

    // ****************************************
    // Enable masks
    // ****************************************

    // Event mask written by the enable command
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evm_ff <= iesb_pkg::EVM_RST;
        end else if (ce) begin
            if (cmd_valid && cmd_code == iesb_pkg::CMD_WR_EVM) begin
                evm_ff <= cmd_data[7:0];
            end
        end
    end

    // Activity mask, unused positions dropped
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            oen_ff <= iesb_pkg::OPR_RST;
        end else if (ce) begin
            if (cmd_valid && cmd_code == iesb_pkg::CMD_WR_OENA) begin
                oen_ff <= cmd_data[15:0] & iesb_pkg::OPR_USED;
            end
        end
    end

    // ****************************************
    // Activity condition and events
    // ****************************************

    // Condition bits from the running activities
    always_comb begin
        nxt_cond = '0;
        nxt_cond[iesb_pkg::OPR_RNG] = autorange_switching;
        nxt_cond[iesb_pkg::OPR_REC] = memory_recording_active &
            ~pretrigger_fill & ~trig_wait;
        nxt_cond[iesb_pkg::OPR_TRG] = trig_wait & recording_armed;
        nxt_cond[iesb_pkg::OPR_SYN] = sync_locked & sync_enabled;
        nxt_cond[iesb_pkg::OPR_SAV] = SYNC_AVAIL_EN & sync_available;
        nxt_cond[iesb_pkg::OPR_AVG] = averaging_active;
        nxt_cond[iesb_pkg::OPR_CAL] = calc_running;
        nxt_cond = nxt_cond & iesb_pkg::OPR_USED;
    end

    // Condition register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cond_ff <= iesb_pkg::OPR_RST;
        end else if (ce) begin
            cond_ff <= nxt_cond;
        end
    end

    // An activity starting is an event
    assign oev_if.set_bits = nxt_cond & ~cond_ff;
    assign oev_if.clr_bits = {iesb_pkg::OPR_W{(cmd_valid &&
        cmd_code == iesb_pkg::CMD_RD_OEVT) || is_cls}};

    // Activity event latch
    iesb_event_latch #(
        .W(iesb_pkg::OPR_W),
        .USED(iesb_pkg::OPR_USED),
        .RST(iesb_pkg::OPR_RST)
    ) u_oev (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .lif(oev_if.lat)
    );

    // ****************************************
    // Answer buffer
    // ****************************************

    // Load answer on a query, strobe it on a read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rsp_data_ff <= '0;
            rsp_valid_ff <= 1'b0;
        end else if (ce) begin
            rsp_valid_ff <= talk_ok;
            if (is_query) begin
                unique case (cmd_code)
                    iesb_pkg::CMD_RD_EVL: begin
                        rsp_data_ff <= DATA_W'(evl_if.val_bits);
                    end
                    iesb_pkg::CMD_RD_EVM: begin
                        rsp_data_ff <= DATA_W'(evm_ff);
                    end
                    iesb_pkg::CMD_RD_OCON: begin
                        rsp_data_ff <= DATA_W'(cond_ff);
                    end
                    iesb_pkg::CMD_RD_OEVT: begin
                        rsp_data_ff <= DATA_W'(oev_if.val_bits);
                    end
                    default: begin
                        rsp_data_ff <= DATA_W'(oen_ff);
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Error queue entries
    // ****************************************

    // One entry a cycle; command errors first
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            err_push_ff <= 1'b0;
            err_code_ff <= '0;
        end else if (ce) begin
            err_push_ff <= cmd_error | exec_error | dev_error | query_err;
            if (cmd_error) begin
                err_code_ff <= iesb_pkg::ERR_CMD;
            end else if (exec_error) begin
                err_code_ff <= iesb_pkg::ERR_EXE;
            end else if (dev_error) begin
                err_code_ff <= iesb_pkg::ERR_DEV;
            end else if (query_err) begin
                err_code_ff <= iesb_pkg::ERR_QRY;
            end
        end
    end

    // ****************************************
    // Summary flags
    // ****************************************

    // Masked latches feed the status byte bits
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evsum_ff <= 1'b0;
            asum_ff <= 1'b0;
        end else if (ce) begin
            evsum_ff <= |(evl_if.val_bits & evm_ff);
            asum_ff <= |(oev_if.val_bits & oen_ff);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign err_push = err_push_ff;
    assign err_code = err_code_ff;
    assign event_summary_flag = evsum_ff;
    assign activity_summary_flag = asum_ff;
    assign opc_pending = opc_wait_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    opc_done_a: assert property (
        ce && opc_wait_ff && exec_idle && cmd_code != iesb_pkg::CMD_OPC
        |=> evl_if.val_bits[0] && !opc_wait_ff)
    else $error("completion not latched");

    query_err_a: assert property (
        ce && talk_req && !answer_held |=> evl_if.val_bits[2] &&
        err_push && !rsp_valid)
    else $error("read without query not flagged");

    dev_err_a: assert property (
        ce && dev_error && !cmd_error && !exec_error |=>
        evl_if.val_bits[3] && err_push &&
        err_code == iesb_pkg::ERR_DEV)
    else $error("device error not reported");

    exec_err_a: assert property (
        ce && exec_error && !cmd_error |=> evl_if.val_bits[4] &&
        err_code == iesb_pkg::ERR_EXE)
    else $error("execution error not reported");

    cmd_err_a: assert property (
        ce && cmd_error |=> evl_if.val_bits[5] &&
        err_code == iesb_pkg::ERR_CMD)
    else $error("command error not reported");

    user_req_a: assert property (
        ce && local_to_manual |=> evl_if.val_bits[6])
    else $error("user request lost");

    sync_off_a: assert property (
        ce && !sync_enabled |=> !cond_ff[8])
    else $error("sync bit set while sync off");

    rec_gate_a: assert property (
        ce && (pretrigger_fill || trig_wait) |=> !cond_ff[3])
    else $error("recording bit set while waiting");

    zero_bits_a: assert property (
        (cond_ff & ~iesb_pkg::OPR_USED) == '0 &&
        !oev_if.val_bits[15] && !evl_if.val_bits[1])
    else $error("unused bit not zero");

    ev_sum_a: assert property (
        ce && |(evl_if.val_bits & evm_ff) |=> event_summary_flag)
    else $error("event summary missing");

    act_sum_a: assert property (
        ce && !(|(oev_if.val_bits & oen_ff)) && oev_if.set_bits == '0
        && cmd_code != iesb_pkg::CMD_WR_OENA
        |=> ##1 ce |-> !activity_summary_flag)
    else $error("activity summary without cause");

endmodule

`default_nettype wire

// [hdl/iesb_pkg.sv]
// Purpose: constants and types shared by the status bank
// Assumes: one clock, commands already decoded upstream
// Notes: widths and bit positions follow the status tables
// Behaviour
// - OPC sets bit 0 once commands finish
// - Bit 2 on read-without-query or unread answer
// - Bit 3 and code -300 on device errors
// - Bit 4 and code -200 on execution errors
// - Bit 5 and code -100 on command errors
// - Bit 6 when local key forces manual
// - Bit 7 set at every power-on
// - Event latch read-clears; bit 1 unused
// - Event mask written and read back
// - Activity condition plus latched activity events
// - Bit 2 while autorange switches ranges
// - Bit 3 only while recording really runs
// - Bit 5 while armed recording awaits trigger
// - Bit 8 on sync lock; zero when off
// - Bit 9 optional sync-present indication
// - Bit 10 while averaging; dips between cycles
// - Bit 12 while a calculation runs
// - Bit 15 zero; other unused bits zero
// - Summary flag from masked event latch
// - Activity summary from masked activity events
`default_nettype none

package iesb_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int EVL_W = 8;
    localparam int OPR_W = 16;

    // ****************************************
    // Event latch bit positions and values
    // ****************************************
    localparam int EVL_OPC = 0;
    localparam int EVL_QRY = 2;
    localparam int EVL_DEV = 3;
    localparam int EVL_EXE = 4;
    localparam int EVL_CMD = 5;
    localparam int EVL_URQ = 6;
    localparam int EVL_PON = 7;
    localparam logic [7:0] EVL_USED = 8'hFD;
    localparam logic [7:0] EVL_RST = 8'h80;
    localparam logic [7:0] EVM_RST = 8'h00;

    // ****************************************
    // Activity bit positions and values
    // ****************************************
    localparam int OPR_RNG = 2;
    localparam int OPR_REC = 3;
    localparam int OPR_TRG = 5;
    localparam int OPR_SYN = 8;
    localparam int OPR_SAV = 9;
    localparam int OPR_AVG = 10;
    localparam int OPR_CAL = 12;
    localparam int OPR_ZERO = 15;
    localparam logic [15:0] OPR_USED = 16'h172C;
    localparam logic [15:0] OPR_RST = 16'h0000;

    // ****************************************
    // Error queue codes (two's complement)
    // ****************************************
    localparam logic [15:0] ERR_CMD = 16'hFF9C;
    localparam logic [15:0] ERR_EXE = 16'hFF38;
    localparam logic [15:0] ERR_DEV = 16'hFED4;
    localparam logic [15:0] ERR_QRY = 16'hFE70;

    // Decoded controller commands
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_RD_EVL = 4'h1,
        CMD_RD_EVM = 4'h2,
        CMD_WR_EVM = 4'h3,
        CMD_RD_OCON = 4'h4,
        CMD_RD_OEVT = 4'h5,
        CMD_RD_OENA = 4'h6,
        CMD_WR_OENA = 4'h7,
        CMD_CLS = 4'h8,
        CMD_OPC = 4'h9
    } iesb_cmd_type;

    // Answer buffer state
    typedef enum logic {
        RSP_IDLE = 1'b0,
        RSP_HELD = 1'b1
    } iesb_rsp_type;

endpackage

`default_nettype wire

// [hdl/iesb_latch_if.sv]
// Purpose: carries set, clear and value of one sticky latch
// Assumes: width matches the latch instance
// Notes: owner drives set and clear, latch returns value
`timescale 1ns/1ps
`default_nettype none

interface iesb_latch_if #(parameter int W = 8);
    logic [W-1:0] set_bits; // Per-bit set requests
    logic [W-1:0] clr_bits; // Per-bit clear requests
    logic [W-1:0] val_bits; // Latched value
    modport ctl (output set_bits, output clr_bits, input val_bits);
    modport lat (input set_bits, input clr_bits, output val_bits);
endinterface

`default_nettype wire

// [hdl/iesb_event_latch.sv]
// Purpose: sticky event latch with per-bit set and clear
// Assumes: set and clear are one-cycle requests
// Notes: a set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module iesb_event_latch #(
    parameter int W = 8,
    parameter logic [W-1:0] USED = '1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock, reset and freeze
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Latch port
    iesb_latch_if.lat lif
);
    logic [W-1:0] val_ff; // Latched events

    if (W < 1) begin : g_chk
        $error("latch width must be positive");
    end

    // Set beats clear; unused positions stay zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            val_ff <= RST & USED;
        end else if (ce) begin
            val_ff <= ((val_ff & ~lif.clr_bits) | lif.set_bits) & USED;
        end
    end

    assign lif.val_bits = val_ff;
endmodule

`default_nettype wire

// [hdl/iesb_query_guard.sv]
// Purpose: tracks the buffered answer and spots query errors
// Assumes: one controller, commands and reads never overlap
// Notes: a read in the same cycle as a command is served first
`timescale 1ns/1ps
`default_nettype none

module iesb_query_guard (
    // Clock, reset and freeze
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Controller activity
    input wire logic query_cmd,
    input wire logic other_cmd,
    input wire logic talk_req,
    // Results
    output logic query_err,
    output logic talk_ok,
    output logic answer_held
);
    iesb_pkg::iesb_rsp_type state_ff; // Answer buffer state
    iesb_pkg::iesb_rsp_type nxt_state; // Next buffer state
    logic any_cmd; // Any new command

    assign any_cmd = query_cmd | other_cmd;
    assign answer_held = (state_ff == iesb_pkg::RSP_HELD);
    assign talk_ok = talk_req & answer_held;
    // Read with nothing asked, or answer left unread
    assign query_err = (talk_req & ~answer_held) |
        (any_cmd & answer_held & ~talk_req);

    // Next state of the answer buffer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            iesb_pkg::RSP_IDLE: begin
                if (query_cmd) begin
                    nxt_state = iesb_pkg::RSP_HELD;
                end
            end
            iesb_pkg::RSP_HELD: begin
                if (query_cmd) begin
                    nxt_state = iesb_pkg::RSP_HELD;
                end else if (talk_req | other_cmd) begin
                    nxt_state = iesb_pkg::RSP_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= iesb_pkg::RSP_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end
endmodule

`default_nettype wire

// [testbench/iesb_ctl_model.sv]
// Purpose: controller model issuing decoded commands and reads
// Assumes: one command or read in flight at a time
// Notes: released data lines show a changed pattern
`timescale 1ns/1ps
`default_nettype none

module iesb_ctl_model (
    // Clock
    input wire logic clk_sys,
    // Command and read strobes
    output logic cmd_valid,
    output var iesb_pkg::iesb_cmd_type cmd_code,
    output logic [15:0] cmd_data,
    output logic talk_req
);
    // ****************************************
    // Bus cycles
    // ****************************************
    // Idle levels at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = iesb_pkg::CMD_NONE;
        cmd_data = 16'h0000;
        talk_req = 1'b0;
    end

    // One command, held across one edge
    task automatic cmd(input iesb_pkg::iesb_cmd_type c,
                       input logic [15:0] d);
        @(posedge clk_sys) #1;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_data = d;
        @(posedge clk_sys) #1;
        cmd_valid = 1'b0;
        cmd_code = iesb_pkg::CMD_NONE;
        cmd_data = ~d; // Released lines show the inverted data
    endtask

    // One read of the held answer
    task automatic talk();
        @(posedge clk_sys) #1;
        talk_req = 1'b1;
        @(posedge clk_sys) #1;
        talk_req = 1'b0;
    endtask
endmodule

`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the status bank
// Assumes: default parameters, clock enable mostly high
// Notes: power-on reads first, then event rows, hand-written cases after
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ****************************************
    // Signals and rows
    // ****************************************
    logic clk_sys = 1'b0; // 250 MHz clock
    logic rstn = 1'b0; // Active-low reset
    logic ce = 1'b1; // Clock enable
    logic [3:0] ev = 4'h0; // Cmd, exec, dev, local pulses
    logic exec_idle = 1'b0; // Earlier commands done
    logic [9:0] act = 10'h000; // Activity inputs
    logic cmd_valid;
    iesb_pkg::iesb_cmd_type cmd_code;
    logic [15:0] cmd_data;
    logic talk_req;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic err_push;
    logic [15:0] err_code;
    logic esf;
    logic asf;
    logic opc_pending;
    int n_mismatch = 0;
    int n_compared = 0;
    // Pulses, expected queue code, expected latch
    typedef struct {
        logic [3:0] ev;
        logic [15:0] code;
        logic [15:0] evl;
    } iesb_row_type;
    iesb_row_type rows [5] = '{
        '{4'h1, 16'hFF9C, 16'h0020},
        '{4'h2, 16'hFF38, 16'h0010},
        '{4'h4, 16'hFED4, 16'h0008},
        '{4'h8, 16'hFED4, 16'h0040},
        '{4'h5, 16'hFF9C, 16'h0028}
    };

    always #2 clk_sys = ~clk_sys;

    iesb_ctl_model CTL (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .talk_req(talk_req));

    iesb_status_bank DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .talk_req(talk_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .exec_idle(exec_idle), .cmd_error(ev[0]), .exec_error(ev[1]),
        .dev_error(ev[2]), .local_to_manual(ev[3]),
        .err_push(err_push), .err_code(err_code),
        .autorange_switching(act[0]), .memory_recording_active(act[1]),
        .pretrigger_fill(act[2]), .trig_wait(act[3]),
        .recording_armed(act[4]), .sync_locked(act[5]),
        .sync_enabled(act[6]), .sync_available(act[7]),
        .averaging_active(act[8]), .calc_running(act[9]),
        .event_summary_flag(esf), .activity_summary_flag(asf),
        .opc_pending(opc_pending));

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Query, read back, compare the answer
    task automatic q(input iesb_pkg::iesb_cmd_type c,
                     input logic [15:0] e);
        CTL.cmd(c, 16'h0000);
        CTL.talk();
        chk({15'h0000, rsp_valid}, 16'h0001);
        chk(rsp_data, e);
    endtask

    // Counts and verdict
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #20000;
        n_mismatch++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        chk({11'h000, rsp_valid, err_push, esf, asf, opc_pending}, 16'h0000);
        repeat (10) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        q(iesb_pkg::CMD_RD_EVL, 16'h0080);
        q(iesb_pkg::CMD_RD_EVL, 16'h0000);
        foreach (rows[i]) begin
            @(posedge clk_sys) #1;
            ev = rows[i].ev;
            @(posedge clk_sys) #1;
            ev = 4'h0;
            chk({15'h0000, err_push}, {15'h0000, |rows[i].ev[2:0]});
            chk(err_code, rows[i].code);
            q(iesb_pkg::CMD_RD_EVL, rows[i].evl);
        end
        // Completion wait and summary flag
        CTL.cmd(iesb_pkg::CMD_WR_EVM, 16'h0001);
        q(iesb_pkg::CMD_RD_EVM, 16'h0001);
        CTL.cmd(iesb_pkg::CMD_OPC, 16'h0000);
        chk({15'h0000, opc_pending}, 16'h0001);
        exec_idle = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({15'h0000, esf}, 16'h0001);
        q(iesb_pkg::CMD_RD_EVL, 16'h0001);
        // Read with nothing held, then an unread answer
        CTL.talk();
        chk({14'h0000, rsp_valid, err_push}, 16'h0001);
        chk(err_code, 16'hFE70);
        CTL.cmd(iesb_pkg::CMD_RD_EVM, 16'h0000);
        CTL.cmd(iesb_pkg::CMD_WR_EVM, 16'h0004);
        chk({15'h0000, err_push}, 16'h0001);
        q(iesb_pkg::CMD_RD_EVL, 16'h0004);
        // Activity conditions and events
        act = 10'h3FF;
        repeat (2) @(posedge clk_sys);
        q(iesb_pkg::CMD_RD_OCON, 16'h1724);
        act = 10'h3B3;
        repeat (2) @(posedge clk_sys);
        q(iesb_pkg::CMD_RD_OCON, 16'h160C);
        q(iesb_pkg::CMD_RD_OEVT, 16'h172C);
        q(iesb_pkg::CMD_RD_OEVT, 16'h0000);
        CTL.cmd(iesb_pkg::CMD_WR_OENA, 16'h0400);
        act = 10'h0B3;
        repeat (2) @(posedge clk_sys);
        q(iesb_pkg::CMD_RD_OCON, 16'h020C);
        act = 10'h1B3;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({15'h0000, asf}, 16'h0001);
        q(iesb_pkg::CMD_RD_OEVT, 16'h0400);
        q(iesb_pkg::CMD_RD_OENA, 16'h0400);
        // Frozen clock enable drops an error, clear-status empties latch
        ce = 1'b0;
        @(posedge clk_sys) #1;
        ev = 4'h1;
        @(posedge clk_sys) #1;
        ce = 1'b1;
        ev = 4'h8;
        chk({15'h0000, err_push}, 16'h0000);
        @(posedge clk_sys) #1;
        ev = 4'h0;
        CTL.cmd(iesb_pkg::CMD_CLS, 16'h0000);
        q(iesb_pkg::CMD_RD_EVL, 16'h0000);
        // Second power-up in mid-run
        rstn = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        q(iesb_pkg::CMD_RD_EVL, 16'h0080);
        wrap_up();
    end
endmodule

`default_nettype wire
